// file: psl_strap_loader.sv
// strap capture, configuration registers and address match for the phy
//
// Behaviour
// - address straps are latched into a register when hardware reset ends
// - with bypass clear, a management frame is answered only if its address matches ours
// - the management address seeds the transmit scrambler
// - straps give addresses 0 to 7; higher ones only by software write
// - software may write a new five-bit address; it is used from then on
// - address bits 0,1,2 come from rx_er, rx_clk and rxd3 pins
// - with bypass set, management writes are accepted at any address
// - at reset release, speed, duplex, negotiation load from mode straps
// - after loading, the block's configuration comes from register bits
// - soft reset rebuilds configuration from register values, not straps
// - codes 000..011 give fixed 10/100 half/full with negotiation off
// - fixed 100 half: carrier sense on tx and rx; 100 full: rx only
// - code 100 negotiates, advertising only 100 half duplex
// - code 101 is repeater, negotiating 100 half, carrier sense rx only
// - code 110 wakes powered down; leave by new mode then soft reset
// - code 111 negotiates with all abilities advertised
// - mode bits 0,1,2 come from rxd0, rxd1 and col/crs_dv pins
// - interface strap caught at reset release; low mii, high rmii
// - interface bit loads from strap, then interface follows the bit
// - on soft reset the interface bit governs and the strap is ignored
// - writing one to control bit 15 starts soft reset; hardware clears it
// - soft-reset-immune bits survive soft reset; hardware reset clears all
//
// The address map and the APB register port are this design's own decisions.
`default_nettype none
module psl_strap_loader
   import psl_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic rx_er_pin,
   input wire logic rx_clk_pin,
   input wire logic rxd3_pin,
   input wire logic rxd0_pin,
   input wire logic rxd1_pin,
   input wire logic col_crs_dv_pin,
   input wire logic rxd2_pin,
   output logic [6:0] strap_pin_oe,
   input wire psl_frame_t mgmt_frame,
   output logic mgmt_frame_accept,
   output logic [4:0] scram_seed,
   output psl_cfg_t active_cfg,
   output logic rmii_sel,
   output logic power_down
);
   typedef enum logic [1:0] {ST_CAPTURE, ST_RUN, ST_SOFT} psl_state_t;

   psl_state_t state_r;
   logic [8:0] soft_cnt_r;
   logic [4:0] mgmt_addr_r;
   logic [2:0] mode_r;
   logic iface_select_bit_r;
   logic addr_match_bypass_r;
   logic soft_rst_bit_r;
   logic pwrdn_bit_r;
   psl_cfg_t cfg_r;
   logic [2:0] mgmt_addr_strap_r;
   logic [2:0] mode_strap_r;
   logic reduced_iface_strap_r;
   logic [31:0] prdata_r;
   logic pready_r;
   logic pslverr_r;
   logic accept_r;
   logic [6:0] oe_r;
   logic wr_en;
   logic setup;
   logic soft_done;
   logic soft_req;
   logic [2:0] addr_pins;
   logic [2:0] mode_pins;
   psl_cfg_t strap_cfg;
   psl_cfg_t reg_cfg;

   // apb phases and the decoded write enable
   assign setup = psel & ~penable;
   assign wr_en = psel & penable & pready_r & pwrite;
   assign soft_req = wr_en && paddr == REG_CTRL_ADDR
      && pwdata[CTRL_SOFT_RST_BIT];
   assign soft_done = state_r == ST_SOFT
      && soft_cnt_r == 9'(SOFT_RST_CYC - 1);
   // strap pin groups
   assign addr_pins = {rxd3_pin, rx_clk_pin, rx_er_pin};
   assign mode_pins = {col_crs_dv_pin, rxd1_pin, rxd0_pin};
   assign strap_cfg = psl_mode_cfg(mode_pins);
   assign reg_cfg = psl_mode_cfg(mode_r);

   // sequencer: one capture cycle after release, then run or soft reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r <= ST_CAPTURE;
      end else begin
         case (state_r)
            ST_CAPTURE: state_r <= ST_RUN;
            ST_RUN: if (soft_req) state_r <= ST_SOFT;
            ST_SOFT: if (soft_done && !soft_req) state_r <= ST_RUN;
            default: state_r <= ST_RUN;
         endcase
      end
   end

   // soft reset duration counter; a new request restarts it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         soft_cnt_r <= 9'h000;
      end else if (state_r != ST_SOFT || soft_req) begin
         soft_cnt_r <= 9'h000;
      end else if (!soft_done) begin
         soft_cnt_r <= soft_cnt_r + 9'h001;
      end
   end

   // strap snapshot kept for status readback
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mgmt_addr_strap_r <= 3'h0;
         mode_strap_r <= 3'h0;
         reduced_iface_strap_r <= 1'b0;
      end else if (state_r == ST_CAPTURE) begin
         mgmt_addr_strap_r <= addr_pins;
         mode_strap_r <= mode_pins;
         reduced_iface_strap_r <= rxd2_pin;
      end
   end

   // special modes register: soft-reset-immune address, mode, interface
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mgmt_addr_r <= ADDR_RST;
         mode_r <= MODE_RST;
         iface_select_bit_r <= IFACE_RST;
      end else if (state_r == ST_CAPTURE) begin
         mgmt_addr_r <= {2'b00, addr_pins};
         mode_r <= mode_pins;
         iface_select_bit_r <= rxd2_pin;
      end else if (wr_en && paddr == REG_SMODE_ADDR) begin
         mgmt_addr_r <= pwdata[SMODE_ADDR_LSB +: 5];
         mode_r <= pwdata[SMODE_MODE_LSB +: 3];
         iface_select_bit_r <= pwdata[SMODE_IFACE_BIT];
      end
   end

   // mode control register: bypass clears on either reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         addr_match_bypass_r <= BYPASS_RST;
      end else if (state_r == ST_SOFT) begin
         addr_match_bypass_r <= BYPASS_RST;
      end else if (wr_en && paddr == REG_MCTL_ADDR) begin
         addr_match_bypass_r <= pwdata[MCTL_BYPASS_BIT];
      end
   end

   // control and advertisement bits: from straps, register mode, or writes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_r <= '0;
         pwrdn_bit_r <= 1'b0;
      end else if (state_r == ST_CAPTURE) begin
         cfg_r <= strap_cfg;
         pwrdn_bit_r <= 1'b0;
      end else if (state_r == ST_SOFT) begin
         cfg_r <= reg_cfg;
         pwrdn_bit_r <= 1'b0;
      end else if (wr_en && paddr == REG_CTRL_ADDR) begin
         cfg_r.speed100 <= pwdata[CTRL_SPEED_BIT];
         cfg_r.aneg_en <= pwdata[CTRL_ANEG_BIT];
         cfg_r.isolate <= pwdata[CTRL_ISOLATE_BIT];
         cfg_r.full_duplex <= pwdata[CTRL_DUPLEX_BIT];
         pwrdn_bit_r <= pwdata[CTRL_PWRDN_BIT];
      end else if (wr_en && paddr == REG_ADV_ADDR) begin
         cfg_r.adv <= pwdata[ADV_LSB +: 4];
      end
   end

   // self-clearing soft reset bit; a new write wins over the clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         soft_rst_bit_r <= 1'b0;
      end else if (soft_req) begin
         soft_rst_bit_r <= 1'b1;
      end else if (soft_done) begin
         soft_rst_bit_r <= 1'b0;
      end
   end

   // apb slave: answer in the first access cycle, error on unmapped
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r <= 32'h0000_0000;
      end else begin
         pready_r <= setup;
         pslverr_r <= 1'b0;
         prdata_r <= 32'h0000_0000;
         if (setup) begin
            case (paddr)
               REG_CTRL_ADDR: begin
                  prdata_r[CTRL_SOFT_RST_BIT] <= soft_rst_bit_r;
                  prdata_r[CTRL_SPEED_BIT] <= cfg_r.speed100;
                  prdata_r[CTRL_ANEG_BIT] <= cfg_r.aneg_en;
                  prdata_r[CTRL_PWRDN_BIT] <= pwrdn_bit_r;
                  prdata_r[CTRL_ISOLATE_BIT] <= cfg_r.isolate;
                  prdata_r[CTRL_DUPLEX_BIT] <= cfg_r.full_duplex;
               end
               REG_ADV_ADDR: prdata_r[ADV_LSB +: 4] <= cfg_r.adv;
               REG_MCTL_ADDR:
                  prdata_r[MCTL_BYPASS_BIT] <= addr_match_bypass_r;
               REG_SMODE_ADDR: begin
                  prdata_r[SMODE_IFACE_BIT] <= iface_select_bit_r;
                  prdata_r[SMODE_MODE_LSB +: 3] <= mode_r;
                  prdata_r[SMODE_ADDR_LSB +: 5] <= mgmt_addr_r;
               end
               REG_STAT_ADDR: prdata_r[8:0] <= {power_down,
                  state_r == ST_SOFT, reduced_iface_strap_r,
                  mgmt_addr_strap_r, mode_strap_r};
               default: pslverr_r <= 1'b1; // unmapped address
            endcase
         end
      end
   end

   // management frame address match with write bypass
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         accept_r <= 1'b0;
      end else begin
         accept_r <= mgmt_frame.valid && state_r != ST_CAPTURE
            && (mgmt_frame.addr == mgmt_addr_r
            || (addr_match_bypass_r && mgmt_frame.write));
      end
   end

   // strap pins turn to outputs only after the capture cycle
   generate
      for (genvar i = 0; i < 7; i++) begin : g_pin_oe
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               oe_r[i] <= 1'b0;
            end else begin
               oe_r[i] <= state_r != ST_CAPTURE;
            end
         end
      end
   endgenerate

   // outputs driven from register bits
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         scram_seed <= ADDR_RST;
         active_cfg <= '0;
         rmii_sel <= IFACE_RST;
         power_down <= 1'b0;
      end else begin
         scram_seed <= mgmt_addr_r;
         active_cfg <= cfg_r;
         rmii_sel <= iface_select_bit_r;
         power_down <= cfg_r.pwrdn | pwrdn_bit_r;
      end
   end

   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;
   assign mgmt_frame_accept = accept_r;
   assign strap_pin_oe = oe_r;

   // checks of the loader's behaviour
   a_addr_strap_load: assert property (@(posedge pclk) disable iff (!presetn)
      presetn && state_r == ST_CAPTURE
      |=> mgmt_addr_r == {2'b00, $past(addr_pins)})
      else $error("address strap not loaded");
   a_frame_match: assert property (@(posedge pclk) disable iff (!presetn)
      mgmt_frame.valid && state_r == ST_RUN && !addr_match_bypass_r
      |=> accept_r == ($past(mgmt_frame.addr) == $past(mgmt_addr_r)))
      else $error("frame address match wrong");
   a_seed_addr: assert property (@(posedge pclk) disable iff (!presetn)
      ##1 scram_seed == $past(mgmt_addr_r))
      else $error("scrambler seed not the address");
   a_bypass_write: assert property (@(posedge pclk) disable iff (!presetn)
      mgmt_frame.valid && mgmt_frame.write && addr_match_bypass_r
      && state_r != ST_CAPTURE |=> accept_r)
      else $error("bypass write refused");
   a_mode_load: assert property (@(posedge pclk) disable iff (!presetn)
      presetn && state_r == ST_CAPTURE
      |=> cfg_r == psl_mode_cfg($past(mode_pins))
      ##1 active_cfg == $past(cfg_r))
      else $error("mode straps not loaded");
   a_soft_reload: assert property (@(posedge pclk) disable iff (!presetn)
      state_r == ST_SOFT |=> cfg_r == psl_mode_cfg($past(mode_r)))
      else $error("soft reset used straps");
   a_soft_keeps: assert property (@(posedge pclk) disable iff (!presetn)
      state_r == ST_SOFT && !wr_en |=> $stable(mode_r)
      && $stable(iface_select_bit_r) && $stable(mgmt_addr_r))
      else $error("immune bits lost on soft reset");
   a_soft_self_clear: assert property (@(posedge pclk) disable iff (!presetn)
      state_r == ST_SOFT |-> soft_cnt_r < 9'(SOFT_RST_CYC))
      else $error("soft reset overran");
   a_soft_bit_drop: assert property (@(posedge pclk) disable iff (!presetn)
      soft_done && !soft_req |=> !soft_rst_bit_r && state_r == ST_RUN)
      else $error("soft reset bit not cleared");
   a_pin_oe_capture: assert property (@(posedge pclk) disable iff (!presetn)
      presetn && state_r == ST_CAPTURE
      |-> oe_r == 7'h00 ##1 oe_r == 7'h00 ##1 oe_r == 7'h7F)
      else $error("strap pins driven too early");
   a_iface_follow: assert property (@(posedge pclk) disable iff (!presetn)
      presetn && state_r == ST_CAPTURE
      |=> iface_select_bit_r == $past(rxd2_pin)
      ##1 rmii_sel == $past(iface_select_bit_r))
      else $error("interface bit not followed");
   a_pwrdn_mode: assert property (@(posedge pclk) disable iff (!presetn)
      presetn && state_r == ST_CAPTURE && mode_pins == MODE_PWRDN
      |-> ##2 power_down)
      else $error("power-down mode not entered");
   a_apb_answer: assert property (@(posedge pclk) disable iff (!presetn)
      setup |=> pready_r)
      else $error("apb answer late");

   c_soft_reset: cover property (@(posedge pclk) disable iff (!presetn)
      soft_done);
   c_bypass_accept: cover property (@(posedge pclk) disable iff (!presetn)
      accept_r && addr_match_bypass_r);
   c_high_addr: cover property (@(posedge pclk) disable iff (!presetn)
      accept_r && mgmt_addr_r > 5'h07);
   c_rmii_strap: cover property (@(posedge pclk) disable iff (!presetn)
      state_r == ST_CAPTURE && rxd2_pin);
endmodule : psl_strap_loader
`default_nettype wire

// file: psl_pkg.sv
// package for the strap configuration loader: map, fields, timing, decode
`default_nettype none
package psl_pkg;
   // register indices; byte address is four times the index
   localparam int unsigned REG_CTRL_IDX = 0;
   localparam int unsigned REG_ADV_IDX = 4;
   localparam int unsigned REG_MCTL_IDX = 17;
   localparam int unsigned REG_SMODE_IDX = 18;
   localparam int unsigned REG_STAT_IDX = 20;
   localparam logic [7:0] REG_CTRL_ADDR = 8'(REG_CTRL_IDX * 4);
   localparam logic [7:0] REG_ADV_ADDR = 8'(REG_ADV_IDX * 4);
   localparam logic [7:0] REG_MCTL_ADDR = 8'(REG_MCTL_IDX * 4);
   localparam logic [7:0] REG_SMODE_ADDR = 8'(REG_SMODE_IDX * 4);
   localparam logic [7:0] REG_STAT_ADDR = 8'(REG_STAT_IDX * 4);
   // control register field positions
   localparam int unsigned CTRL_SOFT_RST_BIT = 15;
   localparam int unsigned CTRL_SPEED_BIT = 13;
   localparam int unsigned CTRL_ANEG_BIT = 12;
   localparam int unsigned CTRL_PWRDN_BIT = 11;
   localparam int unsigned CTRL_ISOLATE_BIT = 10;
   localparam int unsigned CTRL_DUPLEX_BIT = 8;
   // advertisement field, mode control and special modes fields
   localparam int unsigned ADV_LSB = 5;
   localparam int unsigned MCTL_BYPASS_BIT = 3;
   localparam int unsigned SMODE_IFACE_BIT = 14;
   localparam int unsigned SMODE_MODE_LSB = 5;
   localparam int unsigned SMODE_ADDR_LSB = 0;
   // reset values
   localparam logic [4:0] ADDR_RST = 5'h00;
   localparam logic [2:0] MODE_RST = 3'h0;
   localparam logic IFACE_RST = 1'b0;
   localparam logic BYPASS_RST = 1'b0;
   localparam logic [3:0] ADV_RST = 4'h0;
   // mode code meaning power-down wake-up
   localparam logic [2:0] MODE_PWRDN = 3'h6;
   // soft reset duration
   localparam int unsigned CLK_PERIOD_NS = 4;
   localparam int unsigned SOFT_RST_NS = 1000;
   localparam int unsigned SOFT_RST_CYC =
      (SOFT_RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // configuration that one mode code stands for
   typedef struct packed {
      logic speed100;
      logic aneg_en;
      logic isolate;
      logic full_duplex;
      logic [3:0] adv;
      logic crs_on_tx;
      logic repeater;
      logic pwrdn;
   } psl_cfg_t;

   // management frame seen by the address matcher
   typedef struct packed {
      logic valid;
      logic write;
      logic [4:0] addr;
   } psl_frame_t;

   // default register values for each mode code
   function automatic psl_cfg_t psl_mode_cfg(input logic [2:0] m);
      psl_cfg_t c;
      c = '0;
      case (m)
         3'h0: c.crs_on_tx = 1'b1;
         3'h1: c.full_duplex = 1'b1;
         3'h2: begin
            c.speed100 = 1'b1;
            c.crs_on_tx = 1'b1;
         end
         3'h3: begin
            c.speed100 = 1'b1;
            c.full_duplex = 1'b1;
         end
         3'h4: begin
            c.speed100 = 1'b1;
            c.aneg_en = 1'b1;
            c.adv = 4'h4;
            c.crs_on_tx = 1'b1;
         end
         3'h5: begin
            c.speed100 = 1'b1;
            c.aneg_en = 1'b1;
            c.adv = 4'h4;
            c.repeater = 1'b1;
         end
         3'h6: c.pwrdn = 1'b1;
         default: begin
            c.speed100 = 1'b1;
            c.aneg_en = 1'b1;
            c.full_duplex = 1'b1;
            c.adv = 4'hF;
            c.crs_on_tx = 1'b1;
         end
      endcase
      return c;
   endfunction : psl_mode_cfg
endpackage : psl_pkg
`default_nettype wire

// file: psl_mgmt_model.sv
// management controller model: sends frames and watches the accept pulse
`default_nettype none
module psl_mgmt_model
   import psl_pkg::*;
(
   input wire logic pclk,
   input wire logic mgmt_frame_accept,
   output var psl_frame_t mgmt_frame
);
   timeunit 1ns;
   timeprecision 1ps;

   // idle bus carries a valid of zero
   initial begin
      mgmt_frame = '0;
   end

   // one frame for one cycle, then the answer one cycle later
   task automatic send_frame(input logic w, input logic [4:0] a,
                             output logic acc);
      @(posedge pclk);
      mgmt_frame <= {1'b1, w, a};
      @(posedge pclk);
      mgmt_frame <= {1'b0, ~w, ~a}; // released fields no longer hold
      @(posedge pclk);
      acc = mgmt_frame_accept;
   endtask : send_frame
endmodule : psl_mgmt_model
`default_nettype wire

// file: psl_strap_loader_tb.sv
// self-checking bench for the strap configuration loader
`default_nettype none
module psl_strap_loader_tb
   import psl_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [6:0] pins = 7'h00;
   logic [6:0] strap_pin_oe;
   psl_frame_t mgmt_frame;
   logic mgmt_frame_accept;
   logic [4:0] scram_seed;
   psl_cfg_t active_cfg;
   logic rmii_sel;
   logic power_down;
   int err_total = 0;
   int comparisons = 0;
   // expected bits 13,12,10,8 of ctrl, adv 8:5, {crs_on_tx,repeater,pwrdn}
   localparam logic [31:0] CTRL_TBL [8] = '{32'h0, 32'h0100, 32'h2000,
      32'h2100, 32'h3000, 32'h3000, 32'h0, 32'h3100};
   localparam logic [31:0] ADV_TBL [8] = '{32'h0, 32'h0, 32'h0, 32'h0,
      32'h4, 32'h4, 32'h0, 32'hF};
   localparam logic [31:0] MISC_TBL [8] = '{32'h4, 32'h0, 32'h4, 32'h0,
      32'h4, 32'h2, 32'h1, 32'h4};

   // clock at 250 MHz
   always #2 pclk = ~pclk;

   psl_strap_loader i_psl_strap_loader (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .rx_er_pin(pins[0]),
      .rx_clk_pin(pins[1]), .rxd3_pin(pins[2]), .rxd0_pin(pins[3]),
      .rxd1_pin(pins[4]), .col_crs_dv_pin(pins[5]), .rxd2_pin(pins[6]),
      .strap_pin_oe(strap_pin_oe), .mgmt_frame(mgmt_frame),
      .mgmt_frame_accept(mgmt_frame_accept), .scram_seed(scram_seed),
      .active_cfg(active_cfg), .rmii_sel(rmii_sel),
      .power_down(power_down)
   );

   psl_mgmt_model i_psl_mgmt_model (
      .pclk(pclk), .mgmt_frame_accept(mgmt_frame_accept),
      .mgmt_frame(mgmt_frame)
   );

   // compare and count
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         err_total++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   // counts and verdict, then stop
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : print_verdict

   // one apb transfer, held until pready is seen high
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] r,
                      output logic e);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) err_total++;
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   // hardware reset with given straps; pins change once captured
   task automatic hw_reset(input logic [2:0] m, input logic [2:0] a,
                           input logic i);
      @(posedge pclk);
      presetn <= 1'b0;
      pins <= {i, m, a};
      repeat (2) @(posedge pclk);
      check(32'(strap_pin_oe), 32'h0);
      presetn <= 1'b1;
      repeat (2) @(posedge pclk);
      pins <= ~{i, m, a};
      repeat (3) @(posedge pclk);
   endtask : hw_reset

   // every mode code and every strap address, both interface levels
   task automatic mode_table;
      logic [31:0] r;
      logic [31:0] x;
      logic e;
      logic [2:0] m;
      logic [2:0] a;
      for (int k = 0; k < 8; k++) begin
         m = 3'(k);
         a = 3'(7 - k);
         hw_reset(m, a, m[0]);
         check(32'(strap_pin_oe), 32'h7F);
         apb(1'b0, REG_CTRL_ADDR, 32'h0, r, e);
         check(r & 32'h3500, CTRL_TBL[k]);
         apb(1'b0, REG_ADV_ADDR, 32'h0, r, e);
         check((r >> 5) & 32'hF, ADV_TBL[k]);
         apb(1'b0, REG_SMODE_ADDR, 32'h0, r, e);
         x = (32'(m[0]) << 14) | (32'(m) << 5) | 32'(a);
         check(r & 32'h40FF, x);
         apb(1'b0, REG_STAT_ADDR, 32'h0, r, e);
         check(r, 32'({MISC_TBL[k][0], 1'b0, m[0], a, m}));
         check(32'(scram_seed), 32'(a));
         check(32'(rmii_sel), 32'(m[0]));
         check(32'({active_cfg.crs_on_tx, active_cfg.repeater, power_down}),
               MISC_TBL[k]);
      end
   endtask : mode_table

   // address match, bypass, software address and an unmapped access
   task automatic frames;
      logic [31:0] r;
      logic e;
      logic acc;
      hw_reset(3'h7, 3'h5, 1'b0);
      i_psl_mgmt_model.send_frame(1'b0, 5'h05, acc);
      check(32'(acc), 32'h1);
      i_psl_mgmt_model.send_frame(1'b1, 5'h06, acc);
      check(32'(acc), 32'h0);
      apb(1'b1, REG_MCTL_ADDR, 32'h8, r, e);
      i_psl_mgmt_model.send_frame(1'b1, 5'h06, acc);
      check(32'(acc), 32'h1);
      i_psl_mgmt_model.send_frame(1'b0, 5'h06, acc);
      check(32'(acc), 32'h0);
      apb(1'b1, REG_SMODE_ADDR, 32'hF3, r, e);
      repeat (2) @(posedge pclk);
      check(32'(scram_seed), 32'h13);
      i_psl_mgmt_model.send_frame(1'b0, 5'h13, acc);
      check(32'(acc), 32'h1);
      i_psl_mgmt_model.send_frame(1'b0, 5'h05, acc);
      check(32'(acc), 32'h0);
      apb(1'b0, 8'h0C, 32'h0, r, e);
      check(r, 32'h0); // unmapped read gives zero
      check(32'(e), 32'h1); // unmapped read refused
      // software control and advertisement writes reach the outputs
      apb(1'b1, REG_CTRL_ADDR, 32'h0C00, r, e);
      apb(1'b1, REG_ADV_ADDR, 32'h00A0, r, e);
      apb(1'b0, REG_CTRL_ADDR, 32'h0, r, e);
      check(r & 32'h3D00, 32'h0C00);
      apb(1'b0, REG_ADV_ADDR, 32'h0, r, e);
      check((r >> 5) & 32'hF, 32'h5);
      check(32'({active_cfg.isolate, active_cfg.adv, power_down}), 32'h2B);
   endtask : frames

   // wake from power-down mode by new mode and soft reset
   task automatic soft_reset;
      logic [31:0] r;
      logic e;
      int n;
      hw_reset(3'h6, 3'h2, 1'b1);
      check(32'(power_down), 32'h1);
      apb(1'b1, REG_SMODE_ADDR, 32'h4062, r, e);
      apb(1'b1, REG_MCTL_ADDR, 32'h8, r, e);
      apb(1'b1, REG_CTRL_ADDR, 32'h8000, r, e);
      apb(1'b0, REG_CTRL_ADDR, 32'h0, r, e);
      check(r & 32'h8000, 32'h8000);
      n = 0;
      while (r[15] !== 1'b0 && n < 200) begin
         apb(1'b0, REG_CTRL_ADDR, 32'h0, r, e);
         n++;
      end
      check(r & 32'hB500, 32'h2100);
      repeat (2) @(posedge pclk);
      check(32'(power_down), 32'h0);
      check(32'(rmii_sel), 32'h1);
      apb(1'b0, REG_SMODE_ADDR, 32'h0, r, e);
      check(r & 32'h40FF, 32'h4062);
      apb(1'b0, REG_MCTL_ADDR, 32'h0, r, e);
      check(r & 32'h8, 32'h0);
   endtask : soft_reset

   // watchdog against a hang
   initial begin
      #100000;
      err_total++;
      print_verdict();
   end

   // main sequence
   initial begin
      repeat (2) @(posedge pclk);
      mode_table();
      frames();
      soft_reset();
      print_verdict();
   end
endmodule : psl_strap_loader_tb
`default_nettype wire
